// file: core/asi_pkg.sv
package asi_pkg;
  localparam int ASI_AW = 8;
  localparam int ASI_DW = 32;
  localparam logic [7:0] ASI_FLAG_OFS = 8'h00;
  localparam logic [7:0] ASI_DATA_OFS = 8'h04;
  localparam logic [7:0] ASI_CTL1_OFS = 8'h08;
  localparam logic [7:0] ASI_CTL2_OFS = 8'h0c;
  localparam logic [7:0] ASI_RATE_OFS = 8'h10;
  // flag_reg bits
  localparam int F_TXBE = 7;
  localparam int F_TXDONE = 6;
  localparam int F_RXFULL = 5;
  localparam int F_IDLE = 4;
  localparam int F_OVR = 3;
  localparam int F_NOISE = 2;
  localparam int F_FERR = 1;
  localparam logic [7:0] ASI_FLAG_RST = 8'hc0;
  localparam logic [7:0] ASI_RX_FLAGS = 8'h3e;
  // control_one bits
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_NINE = 4;
  localparam logic [7:0] ASI_C1_WMASK = 8'h50;
  localparam logic [7:0] ASI_CTL_RST = 8'h00;
  // control_two bits
  localparam int C2_TXBIE = 7;
  localparam int C2_TXDIE = 6;
  localparam int C2_RXIE = 5;
  localparam int C2_IDLIE = 4;
  localparam int C2_TXON = 3;
  localparam int C2_RXON = 2;
  localparam int C2_BRK = 0;
  // rate_divider_reg fields
  localparam int R_RXEXP = 0;
  localparam int R_TXEXP = 3;
  localparam int R_PRE = 6;
  localparam logic [7:0] ASI_RATE_RST = 8'h00;
  localparam int ASI_BAUD_DIV = 32;
  localparam int ASI_OVERSAMPLE = 16;
  localparam logic [3:0] ASI_SUB_LAST = 4'hf;
  localparam logic [3:0] ASI_SMP_A = 4'h7;
  localparam logic [3:0] ASI_SMP_B = 4'h8;
  localparam logic [3:0] ASI_SMP_C = 4'h9;
  localparam logic [3:0] ASI_FRAME8 = 4'ha;
  localparam logic [3:0] ASI_FRAME9 = 4'hb;
  localparam logic [4:0] ASI_PRE1 = 5'h01;
  localparam logic [4:0] ASI_PRE3 = 5'h03;
  localparam logic [4:0] ASI_PRE4 = 5'h04;
  localparam logic [4:0] ASI_PRE13 = 5'h0d;

  typedef enum logic [2:0] {T_IDLE, T_PRE, T_FRAME, T_BREAK, T_MARK} asi_tstate_type;

  function automatic logic [11:0] asi_tick_div(input logic [1:0] pre, input logic [2:0] ex);
    logic [4:0] p;
    case (pre)
      2'h0: p = ASI_PRE1;
      2'h1: p = ASI_PRE3;
      2'h2: p = ASI_PRE4;
      default: p = ASI_PRE13;
    endcase
    return 12'(((ASI_BAUD_DIV / ASI_OVERSAMPLE) * int'(p)) << ex);
  endfunction : asi_tick_div

  function automatic logic [3:0] asi_frame_bits(input logic nine);
    return nine ? ASI_FRAME9 : ASI_FRAME8;
  endfunction : asi_frame_bits
endpackage : asi_pkg

// file: core/asi_rx.sv
`timescale 1ns/1ns
module asi_rx
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic rx_on,
  input wire logic tick,
  input wire logic nine,
  input wire logic serial_in_pin,
  output logic done,
  output logic idle_seen,
  output logic [8:0] word,
  output logic noise,
  output logic ferr
);
  import asi_pkg::*;
  typedef enum logic [1:0] {R_HUNT, R_START, R_DATA, R_STOP} asi_rstate_type;
  typedef struct packed {
    asi_rstate_type st;
    logic prev;
    logic armed;
    logic [3:0] sub;
    logic [3:0] nbit;
    logic [1:0] smp;
    logic nz;
    logic [7:0] hi;
    logic [8:0] shf;
    logic done;
    logic idle;
    logic [8:0] word;
    logic noise;
    logic ferr;
  } asi_rx_state_type;
  asi_rx_state_type s_reg, s_next;
  logic vote, split;
  logic [7:0] idle_len;

  // majority of three mid-bit samples
  assign vote = (s_reg.smp[0] & s_reg.smp[1]) | (s_reg.smp[0] & serial_in_pin)
    | (s_reg.smp[1] & serial_in_pin);
  assign split = !(s_reg.smp[0] == s_reg.smp[1] && s_reg.smp[1] == serial_in_pin);
  assign idle_len = {asi_frame_bits(nine), 4'h0};

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.idle = 1'b0;
    if (!rx_on)
    begin
      s_next.st = R_HUNT;
      s_next.armed = 1'b1;
      s_next.hi = 8'h00;
      s_next.prev = 1'b1;
    end
    else if (tick)
    begin
      s_next.prev = serial_in_pin;
      s_next.sub = s_reg.sub + 4'h1;
      if (s_reg.sub == ASI_SMP_A)
        s_next.smp[0] = serial_in_pin;
      if (s_reg.sub == ASI_SMP_B)
        s_next.smp[1] = serial_in_pin;
      case (s_reg.st)
        R_HUNT:
        begin
          if (s_reg.prev && !serial_in_pin)
          begin
            s_next.st = R_START;
            s_next.sub = 4'h1;
            s_next.nz = 1'b0;
            s_next.hi = 8'h00;
          end
          else if (serial_in_pin && s_reg.armed)
          begin
            s_next.hi = s_reg.hi + 8'h01;
            if (s_reg.hi == idle_len - 8'h01)
            begin
              s_next.idle = 1'b1;
              s_next.armed = 1'b0;
              s_next.hi = 8'h00;
            end
          end
          else
            s_next.hi = 8'h00;
        end
        R_START:
        begin
          if (s_reg.sub == ASI_SMP_C && vote)
            s_next.st = R_HUNT;
          else if (s_reg.sub == ASI_SMP_C)
            s_next.nz = split;
          else if (s_reg.sub == ASI_SUB_LAST)
          begin
            s_next.st = R_DATA;
            s_next.nbit = 4'h0;
          end
        end
        R_DATA:
        begin
          if (s_reg.sub == ASI_SMP_C)
          begin
            s_next.shf = {vote, s_reg.shf[8:1]};
            s_next.nz = s_reg.nz | split;
          end
          if (s_reg.sub == ASI_SUB_LAST)
          begin
            s_next.nbit = s_reg.nbit + 4'h1;
            if (s_reg.nbit == asi_frame_bits(nine) - 4'h3)
              s_next.st = R_STOP;
          end
        end
        R_STOP:
        begin
          if (s_reg.sub == ASI_SMP_C)
          begin
            s_next.done = 1'b1;
            s_next.word = nine ? s_reg.shf : {1'b0, s_reg.shf[8:1]};
            s_next.noise = s_reg.nz | split;
            s_next.ferr = !vote;
            s_next.st = R_HUNT;
            s_next.armed = 1'b1;
            s_next.hi = 8'h00;
          end
        end
        default: s_next.st = R_HUNT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else if (clk_en)
      s_reg <= s_next;
  end

  assign done = s_reg.done;
  assign idle_seen = s_reg.idle;
  assign word = s_reg.word;
  assign noise = s_reg.noise;
  assign ferr = s_reg.ferr;

  property p_rx_ferr;
    @(posedge pclk) disable iff (!presetn || !clk_en)
    (rx_on && tick && s_reg.st == R_STOP && s_reg.sub == ASI_SMP_C && !vote)
      |=> (done && ferr);
  endproperty
  a_rx_ferr: assert property (p_rx_ferr)
    else $error("missing stop bit not flagged");
endmodule : asi_rx

// file: core/asi_top.sv
`timescale 1ns/1ns
// Summary of operation
// - idle, start, 8/9 bits LSB first, stop
// - start bit low, stop bit high
// - idle pin high; disabled pin released
// - nine-bit mode sends tx_ninth_bit as MSB
// - nine-bit mode stores received MSB
// - enabling transmitter sends one idle frame
// - re-enable mid-frame: idle after, holding dropped
// - flag read then data write clears tx flags
// - write while busy goes to holding
// - write while idle starts frame directly
// - frame end sets done flag, may interrupt
// - holding moved sets empty flag, may interrupt
// - break frames while set, then one mark
// - receiver enable starts start-bit hunt
// - completed character loads holding, sets full
// - flag read then data read clears rx
// - overrun keeps holding, sets overrun flag
// - received break counts as framing error
// - idle frame sets idle flag, may interrupt
// - noise flag set alongside full flag
// - idle is full frame of ones
// - separate baud generators for each direction
// - missing stop bit sets framing error
// - rate is clock over 32, prescale, power
// - framing plus overrun: only overrun set
module asi_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asi_pkg::ASI_AW-1:0] paddr,
  input wire logic [asi_pkg::ASI_DW-1:0] pwdata,
  output logic [asi_pkg::ASI_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_en,
  input wire logic global_irq_mask,
  output logic irq
);
  import asi_pkg::*;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] flags;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] rate;
    logic tx_arm;
    logic rx_arm;
    logic [7:0] hold;
    logic hold_v;
    logic pend_idle;
    logic brk_tail;
    asi_tstate_type ts;
    logic [10:0] tshf;
    logic [3:0] tbit;
    logic [11:0] tdiv;
    logic [3:0] tsub;
    logic [11:0] rdiv;
    logic [7:0] rx_hold;
    logic pin;
    logic oen;
    logic irq;
  } asi_state_type;
  asi_state_type s_reg, s_next;
  logic acc, wr, rd, clr_rx, ttick, rtick, bit_end, frame_end;
  logic [11:0] tx_div, rx_div;
  logic [3:0] tlast;
  logic rx_done, rx_idle, rx_noise, rx_ferr;
  logic [8:0] rx_word;

  // apb access phase completes at the edge where pready is high
  assign acc = psel && penable && s_reg.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign clr_rx = rd && paddr == ASI_DATA_OFS && s_reg.rx_arm;
  // independent baud generators
  assign tx_div = asi_tick_div(s_reg.rate[R_PRE+:2], s_reg.rate[R_TXEXP+:3]);
  assign rx_div = asi_tick_div(s_reg.rate[R_PRE+:2], s_reg.rate[R_RXEXP+:3]);
  assign ttick = s_reg.tdiv == tx_div - 12'h001;
  assign rtick = s_reg.ctl2[C2_RXON] && s_reg.rdiv == rx_div - 12'h001;
  assign bit_end = s_reg.ts != T_IDLE && ttick && s_reg.tsub == ASI_SUB_LAST;
  assign tlast = (s_reg.ts == T_MARK) ? 4'h0 : asi_frame_bits(s_reg.ctl1[C1_NINE]) - 4'h1;
  assign frame_end = bit_end && s_reg.tbit == tlast && s_reg.ts != T_MARK;

  asi_rx u_rx
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .rx_on(s_reg.ctl2[C2_RXON]),
    .tick(rtick),
    .nine(s_reg.ctl1[C1_NINE]),
    .serial_in_pin(serial_in_pin),
    .done(rx_done),
    .idle_seen(rx_idle),
    .word(rx_word),
    .noise(rx_noise),
    .ferr(rx_ferr)
  );

  always_comb
  begin
    s_next = s_reg;
    // bus slave with one wait state
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    if (s_next.pready)
    begin
      case (paddr)
        ASI_FLAG_OFS: s_next.prdata = {24'h000000, s_reg.flags};
        ASI_DATA_OFS: s_next.prdata = {24'h000000, s_reg.rx_hold};
        ASI_CTL1_OFS: s_next.prdata = {24'h000000, s_reg.ctl1};
        ASI_CTL2_OFS: s_next.prdata = {24'h000000, s_reg.ctl2};
        ASI_RATE_OFS: s_next.prdata = {24'h000000, s_reg.rate};
        default:
        begin
          s_next.prdata = 32'h00000000;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    if (wr)
    begin
      case (paddr)
        ASI_DATA_OFS:
        begin
          s_next.hold = pwdata[7:0];
          s_next.hold_v = 1'b1;
          if (s_reg.tx_arm)
          begin
            s_next.flags[F_TXBE] = 1'b0;
            s_next.flags[F_TXDONE] = 1'b0;
            s_next.tx_arm = 1'b0;
          end
        end
        ASI_CTL1_OFS: s_next.ctl1 = (pwdata[7:0] & ASI_C1_WMASK) | (s_reg.ctl1 & ~ASI_C1_WMASK);
        ASI_CTL2_OFS:
        begin
          s_next.ctl2 = pwdata[7:0];
          if (pwdata[C2_TXON] && !s_reg.ctl2[C2_TXON])
          begin
            s_next.pend_idle = 1'b1;
            s_next.hold_v = 1'b0;
          end
        end
        ASI_RATE_OFS: s_next.rate = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd && paddr == ASI_FLAG_OFS)
    begin
      s_next.tx_arm = 1'b1;
      s_next.rx_arm = 1'b1;
    end
    if (clr_rx)
    begin
      s_next.flags = s_next.flags & ~ASI_RX_FLAGS;
      s_next.rx_arm = 1'b0;
    end
    if (!s_next.ctl2[C2_RXON])
      s_next.flags = s_next.flags & ~ASI_RX_FLAGS;
    // receive events win over a clear in the same cycle
    if (rx_done && s_next.ctl2[C2_RXON])
    begin
      if (s_next.flags[F_RXFULL])
        s_next.flags[F_OVR] = 1'b1;
      else
      begin
        s_next.rx_hold = rx_word[7:0];
        s_next.ctl1[C1_RX9] = rx_word[8];
        s_next.flags[F_RXFULL] = 1'b1;
        s_next.flags[F_NOISE] = rx_noise;
        s_next.flags[F_FERR] = rx_ferr;
      end
    end
    if (rx_idle && s_next.ctl2[C2_RXON])
      s_next.flags[F_IDLE] = 1'b1;
    // rx oversampling tick
    if (!s_reg.ctl2[C2_RXON] || rtick)
      s_next.rdiv = 12'h000;
    else
      s_next.rdiv = s_reg.rdiv + 12'h001;
    // transmit bit timing
    if (s_reg.ts != T_IDLE)
    begin
      s_next.tdiv = ttick ? 12'h000 : s_reg.tdiv + 12'h001;
      if (ttick)
        s_next.tsub = s_reg.tsub + 4'h1;
      if (bit_end)
      begin
        s_next.tshf = {1'b1, s_reg.tshf[10:1]};
        s_next.tbit = s_reg.tbit + 4'h1;
        if (s_reg.tbit == tlast)
        begin
          s_next.ts = T_IDLE;
          s_next.tbit = 4'h0;
          if (s_reg.ts != T_MARK)
            s_next.flags[F_TXDONE] = 1'b1;
        end
      end
    end
    // next frame: break, mark, idle, data
    if (s_next.ts == T_IDLE && s_next.ctl2[C2_TXON])
    begin
      s_next.tdiv = 12'h000;
      s_next.tsub = 4'h0;
      s_next.tbit = 4'h0;
      if (s_next.ctl2[C2_BRK])
      begin
        s_next.ts = T_BREAK;
        s_next.tshf = 11'h000;
        s_next.brk_tail = 1'b1;
      end
      else if (s_next.brk_tail)
      begin
        s_next.ts = T_MARK;
        s_next.tshf = 11'h7ff;
        s_next.brk_tail = 1'b0;
      end
      else if (s_next.pend_idle)
      begin
        s_next.ts = T_PRE;
        s_next.tshf = 11'h7ff;
        s_next.pend_idle = 1'b0;
      end
      else if (s_next.hold_v)
      begin
        s_next.ts = T_FRAME;
        s_next.tshf = {1'b1, s_next.ctl1[C1_NINE] ? s_next.ctl1[C1_TX9] : 1'b1,
          s_next.hold, 1'b0};
        s_next.hold_v = 1'b0;
        s_next.flags[F_TXBE] = 1'b1;
      end
    end
    s_next.pin = (s_next.ts != T_IDLE) ? s_next.tshf[0] : 1'b1;
    s_next.oen = s_next.ctl2[C2_TXON];
    s_next.irq = !global_irq_mask && ((s_reg.flags[F_TXBE] && s_reg.ctl2[C2_TXBIE])
      || (s_reg.flags[F_TXDONE] && s_reg.ctl2[C2_TXDIE])
      || ((s_reg.flags[F_RXFULL] || s_reg.flags[F_OVR]) && s_reg.ctl2[C2_RXIE])
      || (s_reg.flags[F_IDLE] && s_reg.ctl2[C2_IDLIE]));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.flags <= ASI_FLAG_RST;
      s_reg.ctl1 <= ASI_CTL_RST;
      s_reg.ctl2 <= ASI_CTL_RST;
      s_reg.rate <= ASI_RATE_RST;
      s_reg.pin <= 1'b1;
    end
    else if (clk_en)
      s_reg <= s_next;
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign serial_out_pin = s_reg.pin;
  assign serial_out_en = s_reg.oen;
  assign irq = s_reg.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);

  property p_start_low;
    (s_reg.ts == T_FRAME && s_reg.tbit == 4'h0) |-> !serial_out_pin;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_stop_high;
    (s_reg.ts == T_FRAME && s_reg.tbit == tlast) |-> serial_out_pin;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("stop bit not high");

  property p_rest_high;
    (s_reg.ts == T_IDLE) |-> serial_out_pin;
  endproperty
  a_rest_high: assert property (p_rest_high)
    else $error("idle line not high");

  property p_pin_off;
    (wr && paddr == ASI_CTL2_OFS && !pwdata[C2_TXON]) |=> !serial_out_en;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin kept after disable");

  property p_direct;
    (wr && paddr == ASI_DATA_OFS && s_reg.ts == T_IDLE && s_reg.ctl2[C2_TXON]
      && !s_reg.ctl2[C2_BRK] && !s_reg.pend_idle && !s_reg.brk_tail)
      |=> (s_reg.ts == T_FRAME && s_reg.flags[F_TXBE] && !s_reg.hold_v) ##1 !serial_out_pin;
  endproperty
  a_direct: assert property (p_direct)
    else $error("idle write did not start frame");

  property p_done;
    frame_end |=> s_reg.flags[F_TXDONE];
  endproperty
  a_done: assert property (p_done)
    else $error("frame end without done flag");

  property p_clr_tx;
    (wr && paddr == ASI_DATA_OFS && s_reg.tx_arm && s_reg.ts != T_IDLE
      && !(bit_end && s_reg.tbit == tlast))
      |=> (!s_reg.flags[F_TXDONE] && !s_reg.flags[F_TXBE] && s_reg.hold_v);
  endproperty
  a_clr_tx: assert property (p_clr_tx)
    else $error("tx flags not cleared");

  property p_take;
    (rx_done && s_reg.ctl2[C2_RXON] && !s_reg.flags[F_RXFULL])
      |=> (s_reg.flags[F_RXFULL] && s_reg.rx_hold == $past(rx_word[7:0]));
  endproperty
  a_take: assert property (p_take)
    else $error("character not moved to holding");

  property p_ovr;
    (rx_done && s_reg.ctl2[C2_RXON] && s_reg.flags[F_RXFULL] && !clr_rx)
      |=> (s_reg.flags[F_OVR] && $stable(s_reg.rx_hold));
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun mishandled");

  property p_ovr_no_fe;
    (rx_done && s_reg.ctl2[C2_RXON] && s_reg.flags[F_RXFULL] && !clr_rx
      && !s_reg.flags[F_FERR]) |=> !s_reg.flags[F_FERR];
  endproperty
  a_ovr_no_fe: assert property (p_ovr_no_fe)
    else $error("framing error set on overrun");

  property p_brk;
    (s_reg.ts == T_BREAK) |-> !serial_out_pin;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break frame not low");

  property p_irq_tx;
    (s_reg.flags[F_TXBE] && s_reg.ctl2[C2_TXBIE] && !global_irq_mask) |=> irq;
  endproperty
  a_irq_tx: assert property (p_irq_tx)
    else $error("empty interrupt missing");

  c_frame: cover property (frame_end);
  c_ovr: cover property (rx_done && s_reg.flags[F_RXFULL]);
  c_break: cover property (s_reg.ts == T_BREAK ##1 s_reg.ts == T_MARK);
  c_idle: cover property (rx_idle);
endmodule : asi_top

// file: bench/asi_far_end.sv
`timescale 1ns/1ns
module asi_far_end
(
  input wire logic pclk,
  input wire logic tx_line,
  input wire logic tx_en,
  input wire logic nine,
  output logic rx_line,
  output logic got,
  output logic [8:0] got_word
);
  int tx_bit = 32;
  int rx_bit = 32;
  logic [8:0] w;

  // frame decoder on the device output
  initial
  begin
    rx_line = 1'b1;
    got = 1'b0;
    got_word = '0;
    forever
    begin
      @(negedge tx_line iff tx_en);
      w = '0;
      repeat (tx_bit / 2) @(posedge pclk);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
        repeat (tx_bit) @(posedge pclk);
        w[i] = tx_line;
      end
      repeat (tx_bit) @(posedge pclk);
      if (tx_line)
      begin
        got_word = w;
        got = 1'b1;
        @(posedge pclk);
        got = 1'b0;
      end
    end
  end

  // one frame towards the device, optional one-sample glitch
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input logic glitch);
    logic b;
    for (int i = 0; i < nb + 2; i++)
    begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : stop;
      for (int c = 0; c < rx_bit; c++)
      begin
        @(posedge pclk);
        rx_line <= (glitch && i == 1 && c >= 16 && c < 18) ? ~b : b;
      end
    end
    @(posedge pclk);
    rx_line <= 1'b1;
  endtask : send
endmodule : asi_far_end

// file: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import asi_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ASI_AW-1:0] paddr;
  logic [ASI_DW-1:0] pwdata, prdata;
  logic sin, sout, sout_en, gmask, irq, got, nine_m, ce;
  logic [8:0] got_word, w0, w1, te;
  logic [16:0] rq[$];
  logic [16:0] re;
  logic [8:0] tq[$];
  logic [7:0] last_rd;
  int num_errors, total_checks, seed;

  asi_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(sin),
    .serial_out_pin(sout), .serial_out_en(sout_en), .global_irq_mask(gmask), .irq(irq));
  asi_far_end u_far (.pclk(pclk), .tx_line(sout), .tx_en(sout_en), .nine(nine_m),
    .rx_line(sin), .got(got), .got_word(got_word));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] m, input logic [8:0] e);
    if (!w)
      rq.push_back({m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    last_rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00, 9'h000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00, m, {1'b0, e});
  endtask : rd

  task automatic wait_rx();
    do
      rd(ASI_FLAG_OFS, 8'h00, 8'h00);
    while (last_rd[F_RXFULL] !== 1'b1);
  endtask : wait_rx

  // read results against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (rq.size() == 0)
        chk(1'b0, "unexpected read");
      else
      begin
        re = rq.pop_front();
        chk({pslverr, prdata[7:0] & re[16:9]} === re[8:0] && prdata[31:8] === 24'h000000,
          "read mismatch");
      end
    end

  // serial words seen by the far end
  always @(posedge got)
  begin
    if (tq.size() == 0)
      chk(1'b0, "unexpected tx word");
    else
    begin
      te = tq.pop_front();
      chk(got_word === te, "tx word mismatch");
    end
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    close_out();
  end

  initial
  begin
    seed = 32'h8ee10c16;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    gmask = 1'b0;
    ce = 1'b1;
    nine_m = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ASI_FLAG_OFS, 8'hff, ASI_FLAG_RST);
    rd(ASI_CTL2_OFS, 8'hff, ASI_CTL_RST);
    apb(1'b0, 8'h40, 8'h00, 8'hff, 9'h100);
    chk(sout === 1'b1 && sout_en === 1'b0, "pin not released");
    for (int nine = 0; nine < 2; nine++)
    begin
      nine_m = nine[0];
      wr(ASI_CTL1_OFS, nine[0] ? 8'h50 : 8'h00);
      rd(ASI_FLAG_OFS, 8'h00, 8'h00);
      wr(ASI_DATA_OFS, 8'($random(seed)));
      wr(ASI_CTL2_OFS, 8'h0c);
      repeat (300) @(posedge pclk);
      chk(sout === 1'b1 && sout_en === 1'b1, "no idle frame");
      rd(ASI_FLAG_OFS, 8'h40, 8'h00);
      repeat (100) @(posedge pclk);
      rd(ASI_FLAG_OFS, 8'h50, 8'h50);
      w0 = {nine[0], 8'($random(seed))};
      w1 = {nine[0], 8'($random(seed))};
      tq.push_back(w0);
      tq.push_back(w1);
      wr(ASI_DATA_OFS, w0[7:0]);
      rd(ASI_FLAG_OFS, 8'h80, 8'h80);
      wr(ASI_DATA_OFS, w1[7:0]);
      rd(ASI_FLAG_OFS, 8'h80, 8'h00);
      w0 = {nine[0], 8'($random(seed))};
      u_far.send(w0, 8 + nine, 1'b1, 1'b0);
      wait_rx();
      rd(ASI_DATA_OFS, 8'hff, w0[7:0]);
      rd(ASI_CTL1_OFS, 8'h80, {w0[8], 7'h0});
      rd(ASI_FLAG_OFS, 8'h20, 8'h00);
      while (tq.size() > 0)
        @(posedge pclk);
      repeat (40) @(posedge pclk);
      wr(ASI_CTL2_OFS, 8'h00);
      repeat (2) @(posedge pclk);
      chk(sout_en === 1'b0, "pin kept");
    end
    nine_m = 1'b0;
    wr(ASI_CTL1_OFS, 8'h00);
    wr(ASI_CTL2_OFS, 8'h0c);
    repeat (400) @(posedge pclk);
    w0 = 9'($random(seed) & 32'hff);
    w1 = 9'($random(seed) & 32'hff);
    u_far.send(w0, 8, 1'b1, 1'b0);
    u_far.send(w1, 8, 1'b1, 1'b0);
    rd(ASI_FLAG_OFS, 8'h28, 8'h28);
    rd(ASI_DATA_OFS, 8'hff, w0[7:0]);
    u_far.send(9'h000, 8, 1'b0, 1'b0);
    wait_rx();
    rd(ASI_FLAG_OFS, 8'h2a, 8'h22);
    rd(ASI_DATA_OFS, 8'hff, 8'h00);
    w0 = 9'($random(seed) & 32'hff);
    u_far.send(w0, 8, 1'b1, 1'b1);
    wait_rx();
    rd(ASI_FLAG_OFS, 8'h26, 8'h24);
    rd(ASI_DATA_OFS, 8'hff, w0[7:0]);
    wr(ASI_CTL2_OFS, 8'h09);
    repeat (200) @(posedge pclk);
    chk(sout === 1'b0, "no break");
    wr(ASI_CTL2_OFS, 8'h08);
    repeat (800) @(posedge pclk);
    chk(sout === 1'b1, "no mark after break");
    wr(ASI_CTL2_OFS, 8'h88);
    repeat (3) @(posedge pclk);
    chk(irq === 1'b1, "no irq");
    gmask <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq === 1'b0, "irq not masked");
    ce <= 1'b0;
    gmask <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq === 1'b0, "irq moved while frozen");
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq === 1'b1, "no irq after freeze");
    wr(ASI_CTL2_OFS, 8'h00);
    wr(ASI_RATE_OFS, 8'h48);
    u_far.tx_bit = ASI_BAUD_DIV * 3 * 2;
    u_far.rx_bit = ASI_BAUD_DIV * 3;
    wr(ASI_CTL2_OFS, 8'h0c);
    repeat (2000) @(posedge pclk);
    w0 = 9'($random(seed) & 32'hff);
    w1 = 9'($random(seed) & 32'hff);
    tq.push_back(w1);
    wr(ASI_DATA_OFS, w1[7:0]);
    u_far.send(w0, 8, 1'b1, 1'b0);
    wait_rx();
    rd(ASI_DATA_OFS, 8'hff, w0[7:0]);
    while (tq.size() > 0)
      @(posedge pclk);
    close_out();
  end
endmodule : tb_top
